// file: rtl/smc_fifo.sv
/*
  Small synchronous FIFO holding captured parallel words.
  Assumes one clock; flush empties it in one cycle.
*/
`default_nettype none

module smc_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 8
) (
  // Clock, reset and flush
  input wire logic   clk,
  input wire logic   reset_n,
  input wire logic   flush,
  // Word stream
  smc_stream_if.fifo s
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } smc_fifo_st_type;

  smc_fifo_st_type r;
  smc_fifo_st_type n;
  logic [AW:0]     used;

  assign used     = r.wp - r.rp;
  assign s.wready = (used != (AW+1)'(DEPTH));
  assign s.rvalid = (r.wp != r.rp);
  assign s.rdata  = r.mem[r.rp[AW-1:0]];

  always_comb begin
    n = r;
    if (s.wvalid && s.wready) begin
      n.mem[r.wp[AW-1:0]] = s.wdata;
      n.wp = r.wp + 1'b1;
    end
    if (s.rready && s.rvalid) begin
      n.rp = r.rp + 1'b1;
    end
    if (flush) begin
      n.wp = '0;
      n.rp = '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule : smc_fifo

`default_nettype wire

// file: rtl/smc_mode_control.sv
/*
  Mode control of a 12-bit serializer/deserializer: pin decode, power-down,
  PLL lock gate, strobe capture FIFO, serial word shifter and word clock.
  Assumes static configuration pins and pin inputs asynchronous to clk.
*/
// What the document asks of this block and of its link partner
// RULE1: Both mode bits low: power down, reset logic
// RULE2: Power-down stops analog and both serial paths
// RULE3: Direction high serializes, low deserializes
// RULE4: Direction echo is inverted direction, combinational
// RULE5: Partner matches mode code to reference range
// RULE6: Deserializer mode code selects edge rate
// RULE7: Rate code selects serial clock multiplier
// RULE8: Rate pins become pulse width in deserializer
// RULE9: Strobe blocked until PLL reports lock
// RULE10: Pulse width code sets word clock low
// RULE11: Power-down output states follow direction
// RULE12: Turned serializer keeps last parallel outputs
// RULE13: Partner tristates its peripheral before turning
// RULE14: Master echo may drive slave direction
// RULE15: Partner holds reference low, clocks strobe
// RULE16: Pass-through forwards serial clock to word clock
// RULE17: Partner picks rate suited to strobe
// RULE18: Word clock falls as parallel data changes
// RULE19: Empty serial slots carry zero words
// RULE20: Settings change only through power-down relock
`default_nettype none

module smc_mode_control #(
  parameter int LOCK_EDGES = smc_pkg::LOCK_EDGES,
  parameter int DEPTH      = smc_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Static configuration pins
  input  wire logic        direction_select,
  input  wire logic        mode_select_hi,
  input  wire logic        mode_select_lo,
  input  wire logic        rate_select_hi,
  input  wire logic        rate_select_lo,
  input  wire logic        passthrough_enable,
  // Parallel side
  input  wire logic        reference_clock_in,
  input  wire logic        strobe_in,
  input  wire logic [11:0] parallel_data_in,
  output logic      [11:0] parallel_data_out,
  output logic             parallel_data_oe,
  output logic             word_clock_out,
  output logic             word_clock_oe,
  output logic             capture_ready,
  // Serial side
  input  wire logic        serial_clock_in,
  input  wire logic        serial_data_in,
  output logic             serial_clock_out,
  output logic             serial_data_out,
  output logic             serial_out_enable,
  // Control and status
  output logic             direction_echo_n,
  output logic             analog_enable,
  output logic             pll_locked,
  output logic      [1:0]  pll_range_sel,
  output logic      [1:0]  rate_mult_sel,
  output logic      [1:0]  edge_rate_sel
);
  localparam int LW = $clog2(LOCK_EDGES) + 1;
  localparam int SW = smc_pkg::SY_W;

  typedef struct packed {
    logic [SW-1:0]      sy1;
    logic [SW-1:0]      sy2;
    logic               ref_d;
    logic               stb_d;
    logic               sclk_d;
    logic               pt_s1;
    logic               pt_s2;
    logic [LW-1:0]      lock_cnt;
    logic               locked;
    logic               cfg_held;
    logic [1:0]         mode_cfg;
    logic [1:0]         rate_cfg;
    smc_pkg::smc_tx_type tx_state;
    logic [11:0]        tx_sh;
    logic [3:0]         tx_bit;
    logic [4:0]         tx_div;
    logic               sclk_o;
    logic               sdat_o;
    logic [11:0]        rx_sh;
    logic [3:0]         rx_bit;
    logic [11:0]        pdata_o;
    logic               wclk_low;
    logic [7:0]         wclk_cnt;
  } smc_st_type;

  smc_st_type r;
  smc_st_type n;
  logic       pd;
  logic       ser;
  logic       ref_rise;
  logic       stb_rise;
  logic       sclk_rise;
  logic       word_done;
  logic [11:0] rx_word;
  logic       pt;
  logic [SW-1:0] pin_vec;

  smc_stream_if #(.W(smc_pkg::DATA_W)) fifo_if ();

  function automatic logic [4:0] tx_cycles(input logic [1:0] code);
    case (code)
      smc_pkg::RATE_OC:   tx_cycles = smc_pkg::TX_CYC_OC;
      smc_pkg::RATE_X7:   tx_cycles = smc_pkg::TX_CYC_X7;
      smc_pkg::RATE_DIV2: tx_cycles = smc_pkg::TX_CYC_DIV2;
      default:            tx_cycles = smc_pkg::TX_CYC_DIV3;
    endcase
  endfunction : tx_cycles

  function automatic logic [7:0] low_cycles(input logic [1:0] code);
    logic [4:0] bits;
    bits = smc_pkg::PW_BITS_7;
    case (code)
      smc_pkg::PW_13_LH: bits = smc_pkg::PW_BITS_13;
      smc_pkg::PW_17_LH: bits = smc_pkg::PW_BITS_17;
      default:           bits = smc_pkg::PW_BITS_7;
    endcase
    low_cycles = 8'(bits * smc_pkg::DES_BIT_CYC);
  endfunction : low_cycles

  // Decoded pin state, all from the second synchroniser stage
  assign pd  = (r.sy2[smc_pkg::SY_MLO +: 2] == smc_pkg::MODE_PD); // RULE1
  assign ser = r.sy2[smc_pkg::SY_DIR]; // RULE3
  assign pt  = r.pt_s2;
  assign ref_rise  = r.sy2[smc_pkg::SY_REF] && !r.ref_d;
  assign stb_rise  = r.sy2[smc_pkg::SY_STB] && !r.stb_d;
  assign sclk_rise = r.sy2[smc_pkg::SY_SCLK] && !r.sclk_d;
  assign rx_word   = {r.rx_sh[10:0], r.sy2[smc_pkg::SY_SDAT]};
  assign word_done = !pd && !ser && sclk_rise && (r.rx_bit == 4'hb);

  // Capture path; a full FIFO refuses strobes, visible on capture_ready
  assign fifo_if.wdata = r.sy2[smc_pkg::SY_PD +: 12];
  assign fifo_if.wvalid = !pd && ser && r.locked && stb_rise; // RULE9
  assign fifo_if.rready = !pd && ser && (r.tx_state == smc_pkg::TX_LOAD);

  smc_fifo #(.W(smc_pkg::DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clk     (clk),
    .reset_n (reset_n),
    .flush   (pd),
    .s       (fifo_if.fifo)
  );

  // Pin order must match the synchroniser positions of the package
  assign pin_vec = {direction_select, mode_select_hi, mode_select_lo,
                    rate_select_hi, rate_select_lo, reference_clock_in,
                    strobe_in, serial_clock_in, serial_data_in,
                    parallel_data_in};

  always_comb begin
    n = r;
    n.sy1    = pin_vec;
    n.sy2    = r.sy1;
    n.ref_d  = r.sy2[smc_pkg::SY_REF];
    n.stb_d  = r.sy2[smc_pkg::SY_STB];
    n.sclk_d = r.sy2[smc_pkg::SY_SCLK];
    n.pt_s1  = passthrough_enable;
    n.pt_s2  = r.pt_s1;
    if (pd) begin
      // Whole core returns to reset, only the synchronisers keep running
      n          = '0; // RULE1 RULE2
      n.sy1      = pin_vec;
      n.sy2      = r.sy1;
      n.ref_d    = r.sy2[smc_pkg::SY_REF];
      n.stb_d    = r.sy2[smc_pkg::SY_STB];
      n.sclk_d   = r.sy2[smc_pkg::SY_SCLK];
      n.pt_s1    = passthrough_enable;
      n.pt_s2    = r.pt_s1;
    end else begin
      if (!r.cfg_held) begin
        // Settings are sampled once per power-up and then frozen
        n.cfg_held = 1'b1; // RULE20
        n.mode_cfg = r.sy2[smc_pkg::SY_MLO +: 2];
        n.rate_cfg = r.sy2[smc_pkg::SY_RLO +: 2];
      end
      if (!r.locked && ref_rise) begin
        n.lock_cnt = r.lock_cnt + 1'b1;
        if (r.lock_cnt == LW'(LOCK_EDGES - 1)) begin
          n.locked = 1'b1; // RULE9
        end
      end
      if (ser) begin
        case (r.tx_state)
          smc_pkg::TX_OFF: begin
            if (r.locked) begin
              n.tx_state = smc_pkg::TX_LOAD;
            end
          end
          smc_pkg::TX_LOAD: begin
            // No captured word: the slot still goes out, as zeros
            n.tx_sh    = fifo_if.rvalid ? fifo_if.rdata : 12'h000; // RULE19
            n.tx_bit   = 4'h0;
            n.tx_div   = 5'h00;
            n.tx_state = smc_pkg::TX_SHIFT;
          end
          smc_pkg::TX_SHIFT: begin
            n.tx_div = r.tx_div + 5'h01;
            if (r.tx_div == 5'h00) begin
              n.sdat_o = r.tx_sh[11];
              n.sclk_o = 1'b0;
            end
            if (r.tx_div == (tx_cycles(r.rate_cfg) >> 1)) begin // RULE7
              n.sclk_o = 1'b1;
            end
            if (r.tx_div == tx_cycles(r.rate_cfg) - 5'h01) begin
              n.tx_div = 5'h00;
              n.tx_sh  = {r.tx_sh[10:0], 1'b0};
              n.tx_bit = r.tx_bit + 4'h1;
              if (r.tx_bit == 4'hb) begin
                n.tx_state = smc_pkg::TX_LOAD;
              end
            end
          end
          default: n.tx_state = smc_pkg::TX_OFF;
        endcase
      end else begin
        // Deserializer; parallel_data_out is loaded only here and cleared to zero in power-down
        n.tx_state = smc_pkg::TX_OFF; // RULE12
        if (r.wclk_low) begin
          if (r.wclk_cnt == 8'h00) begin
            n.wclk_low = 1'b0;
          end else begin
            n.wclk_cnt = r.wclk_cnt - 8'h01;
          end
        end
        if (sclk_rise) begin
          n.rx_sh  = rx_word;
          n.rx_bit = r.rx_bit + 4'h1;
          if (word_done) begin
            n.rx_bit   = 4'h0;
            n.pdata_o  = rx_word; // RULE18
            n.wclk_low = 1'b1;
            n.wclk_cnt = low_cycles(r.rate_cfg) - 8'h01; // RULE8 RULE10
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Echo bypasses every flop so a turned partner follows at once
  assign direction_echo_n  = ~direction_select; // RULE4
  assign analog_enable     = !pd; // RULE2
  assign pll_locked        = r.locked;
  assign capture_ready     = !pd && ser && r.locked && fifo_if.wready;
  assign parallel_data_out = r.pdata_o;
  assign parallel_data_oe  = !pd && !ser; // RULE3 RULE11
  assign word_clock_oe     = ser || !pd; // RULE11
  always_comb begin
    if (ser) begin
      word_clock_out = 1'b1; // RULE11
      if (!pd && pt) begin
        word_clock_out = r.sy2[smc_pkg::SY_SCLK]; // RULE16
      end
    end else begin
      word_clock_out = !r.wclk_low ^ (r.rate_cfg == smc_pkg::PW_7_HL);
    end
  end
  assign serial_out_enable = !pd && (ser ? r.locked : pt);
  assign serial_clock_out  = ser ? r.sclk_o : r.sy2[smc_pkg::SY_STB];
  assign serial_data_out   = ser ? r.sdat_o : 1'b0;
  assign pll_range_sel = (!pd && ser) ? r.mode_cfg : 2'h0;
  assign rate_mult_sel = (!pd && ser) ? r.rate_cfg : 2'h0; // RULE7 RULE8
  assign edge_rate_sel = (!pd && !ser) ? r.mode_cfg : 2'h0; // RULE6

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  AST_PD_RESET: assert property (pd |=> !r.locked && r.tx_bit == 4'h0) // RULE1
    else $error("core state not reset in power-down");
  AST_PD_SERIAL: assert property (pd |-> !serial_out_enable
      && !analog_enable) // RULE2
    else $error("serial or analog active in power-down");
  AST_DIR_ROLE: assert property (!pd |-> parallel_data_oe == !ser) // RULE3
    else $error("parallel drive does not follow direction");
  AST_ECHO: assert property (direction_echo_n != direction_select) // RULE4
    else $error("direction echo not inverted");
  AST_EDGE_RATE: assert property ((!pd && !ser && r.cfg_held)
      |-> edge_rate_sel == r.mode_cfg && edge_rate_sel != 2'h0) // RULE6
    else $error("edge rate not taken from mode code");
  AST_STROBE_GATE: assert property (!r.locked |-> !fifo_if.wvalid) // RULE9
    else $error("strobe accepted before lock");
  AST_LOW_TIME: assert property (word_done
      |=> r.wclk_low && r.wclk_cnt == low_cycles(r.rate_cfg) - 8'h01) // RULE10
    else $error("word clock low time wrong");
  AST_PD_SER_OUT: assert property ((pd && ser)
      |-> word_clock_out && word_clock_oe && !parallel_data_oe) // RULE11
    else $error("serializer power-down outputs wrong");
  AST_PD_DES_OUT: assert property ((pd && !ser)
      |-> !word_clock_oe && !parallel_data_oe) // RULE11
    else $error("deserializer power-down outputs not released");
  AST_HOLD_DATA: assert property ((ser && $past(ser) && !$past(pd))
      |-> $stable(parallel_data_out)) // RULE12
    else $error("parallel outputs changed while serializing");
  AST_PASS: assert property ((ser && !pd && pt)
      |-> word_clock_out == r.sy2[smc_pkg::SY_SCLK]) // RULE16
    else $error("pass-through clock not forwarded");
  AST_FALL_DATA: assert property (word_done
      |=> r.pdata_o == $past(rx_word) && r.wclk_low) // RULE18
    else $error("data change not paired with word clock fall");
  AST_ZERO_FILL: assert property ((!pd && ser
      && r.tx_state == smc_pkg::TX_LOAD && !fifo_if.rvalid)
      |=> r.tx_sh == 12'h000) // RULE19
    else $error("empty slot not filled with zero");
  AST_FROZEN: assert property ((!pd && !$past(pd) && $past(r.cfg_held))
      |-> $stable(r.rate_cfg) && $stable(r.mode_cfg)) // RULE20
    else $error("settings changed without power-down");

  COV_LOCK: cover property (!r.locked ##1 r.locked);
  COV_CAPTURE: cover property (fifo_if.wvalid && fifo_if.wready);
  COV_ZERO: cover property (fifo_if.rready && !fifo_if.rvalid);
  COV_WORD: cover property (word_done);
endmodule : smc_mode_control

`default_nettype wire

// file: rtl/smc_pkg.sv
/*
  Shared constants and types of the serializer/deserializer mode control.
  Assumes a single 50 MHz core clock and static configuration pins.
*/
`default_nettype none

package smc_pkg;

  // Core clock and parallel word
  localparam int CLK_NS     = 20;
  localparam int DATA_W     = 12;
  localparam int FIFO_DEPTH = 8;

  // Reference clock edges counted before the PLL is declared locked
  localparam int LOCK_EDGES = 1024;

  // Receive bit period, least time rounded up to whole cycles
  localparam int DES_BIT_NS  = 160;
  localparam int DES_BIT_CYC = (DES_BIT_NS + CLK_NS - 1) / CLK_NS;

  // Mode select codes
  localparam logic [1:0] MODE_PD   = 2'h0;
  localparam logic [1:0] MODE_FAST = 2'h1;
  localparam logic [1:0] MODE_SLOW = 2'h2;
  localparam logic [1:0] MODE_MED  = 2'h3;

  // Rate select codes (serializer)
  localparam logic [1:0] RATE_OC   = 2'h0;
  localparam logic [1:0] RATE_X7   = 2'h1;
  localparam logic [1:0] RATE_DIV2 = 2'h2;
  localparam logic [1:0] RATE_DIV3 = 2'h3;

  // Pulse width codes (deserializer)
  localparam logic [1:0] PW_7_LH  = 2'h0;
  localparam logic [1:0] PW_7_HL  = 2'h1;
  localparam logic [1:0] PW_13_LH = 2'h2;
  localparam logic [1:0] PW_17_LH = 2'h3;
  localparam logic [4:0] PW_BITS_7  = 5'h07;
  localparam logic [4:0] PW_BITS_13 = 5'h0d;
  localparam logic [4:0] PW_BITS_17 = 5'h11;

  // Core cycles per transmitted bit for each rate code
  localparam logic [4:0] TX_CYC_OC   = 5'h03;
  localparam logic [4:0] TX_CYC_X7   = 5'h04;
  localparam logic [4:0] TX_CYC_DIV2 = 5'h08;
  localparam logic [4:0] TX_CYC_DIV3 = 5'h0c;

  // Positions in the synchronised pin vector
  localparam int SY_PD   = 0;
  localparam int SY_SDAT = 12;
  localparam int SY_SCLK = 13;
  localparam int SY_STB  = 14;
  localparam int SY_REF  = 15;
  localparam int SY_RLO  = 16;
  localparam int SY_MLO  = 18;
  localparam int SY_DIR  = 20;
  localparam int SY_W    = 21;

  typedef enum logic [1:0] {
    TX_OFF   = 2'b00,
    TX_LOAD  = 2'b01,
    TX_SHIFT = 2'b10
  } smc_tx_type;

endpackage : smc_pkg

`default_nettype wire

// file: rtl/smc_stream_if.sv
/*
  Word stream between the mode control and its capture FIFO.
  Assumes both ends on the same clock.
*/
`default_nettype none

interface smc_stream_if #(parameter int W = 12);
  logic [W-1:0] wdata;
  logic         wvalid;
  logic         wready;
  logic [W-1:0] rdata;
  logic         rvalid;
  logic         rready;

  modport writer (output wdata, wvalid, rready,
                  input  wready, rdata, rvalid);
  modport fifo   (input  wdata, wvalid, rready,
                  output wready, rdata, rvalid);
endinterface : smc_stream_if

`default_nettype wire

// file: tb/smc_link_partner.sv
/*
  Far end of the serial link: sends words on a 160 ns bit clock and
  collects the words the block serializes.
  Assumes the block's serial outputs are settled before their clock rises.
*/
`default_nettype none

module smc_link_partner (
  // Towards the block
  input  wire logic serial_clock_out,
  input  wire logic serial_data_out,
  input  wire logic serial_out_enable,
  output logic      serial_clock_in,
  output logic      serial_data_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [11:0] rx_w;
  int          rx_n;
  logic [11:0] rx_q [$];

  initial begin
    serial_clock_in = 1'b0;
    serial_data_in  = 1'b1;
    rx_n            = 0;
  end

  // Clock stands low between frames; offset keeps it off the core edges
  task automatic send_word(input logic [11:0] w);
    #7;
    for (int i = 11; i >= 0; i--) begin
      serial_data_in = w[i];
      #80 serial_clock_in = 1'b1;
      #80 serial_clock_in = 1'b0;
    end
    // Released line must not look like a held bit
    serial_data_in = ~w[0];
  endtask : send_word

  // No framing on the link: word count restarts when output is disabled
  always @(posedge serial_clock_out or negedge serial_out_enable) begin
    if (serial_out_enable !== 1'b1) begin
      rx_n = 0;
    end else begin
      rx_w = {rx_w[10:0], serial_data_out};
      rx_n++;
      if (rx_n == 12) begin
        rx_q.push_back(rx_w);
        rx_n = 0;
      end
    end
  end
endmodule : smc_link_partner

`default_nettype wire

// file: tb/smc_mode_control_tb.sv
/*
  Bench of the mode control: a table of pin settings, then hand tests.
  Assumes the link partner model; lock shortened to four reference edges.
*/
`default_nettype none

module smc_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic       dir;
    logic [1:0] mode;
    logic [1:0] rate;
    logic [4:0] num;
  } smc_row_type;

  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        direction_select = 1'b1;
  logic [1:0]  mode = 2'h0;
  logic [1:0]  rate = 2'h0;
  logic        passthrough_enable = 1'b0;
  logic        strobe_in = 1'b0;
  logic [11:0] parallel_data_in = 12'h000;
  logic [1:0]  rc = 2'h0;
  logic        ref_low = 1'b0;
  wire logic   reference_clock_in;
  logic [11:0] parallel_data_out;
  logic        parallel_data_oe, word_clock_out, word_clock_oe;
  logic        capture_ready, serial_clock_in, serial_data_in;
  logic        serial_clock_out, serial_data_out, serial_out_enable;
  logic        direction_echo_n, analog_enable, pll_locked;
  logic [1:0]  pll_range_sel, rate_mult_sel, edge_rate_sel;
  int          mismatches = 0;
  int          check_count = 0;

  // Reference runs at 12.5 MHz, so serializer rows avoid the fast code
  smc_row_type rows [8] = '{
    '{1'b1, smc_pkg::MODE_MED,  smc_pkg::RATE_OC,   smc_pkg::TX_CYC_OC},
    '{1'b1, smc_pkg::MODE_SLOW, smc_pkg::RATE_X7,   smc_pkg::TX_CYC_X7},
    '{1'b1, smc_pkg::MODE_MED,  smc_pkg::RATE_DIV2, smc_pkg::TX_CYC_DIV2},
    '{1'b1, smc_pkg::MODE_SLOW, smc_pkg::RATE_DIV3, smc_pkg::TX_CYC_DIV3},
    '{1'b0, smc_pkg::MODE_FAST, smc_pkg::PW_7_LH,   smc_pkg::PW_BITS_7},
    '{1'b0, smc_pkg::MODE_SLOW, smc_pkg::PW_7_HL,   smc_pkg::PW_BITS_7},
    '{1'b0, smc_pkg::MODE_MED,  smc_pkg::PW_13_LH,  smc_pkg::PW_BITS_13},
    '{1'b0, smc_pkg::MODE_FAST, smc_pkg::PW_17_LH,  smc_pkg::PW_BITS_17}};

  always #10 clk = ~clk;
  // Reference clock at a quarter of the core rate unless held low
  always @(posedge clk) rc <= rc + 2'h1;
  assign reference_clock_in = rc[1] & ~ref_low;

  smc_mode_control #(.LOCK_EDGES(4)) dut (
    .clk, .reset_n, .direction_select,
    .mode_select_hi(mode[1]), .mode_select_lo(mode[0]),
    .rate_select_hi(rate[1]), .rate_select_lo(rate[0]),
    .passthrough_enable, .reference_clock_in, .strobe_in,
    .parallel_data_in, .parallel_data_out, .parallel_data_oe,
    .word_clock_out, .word_clock_oe, .capture_ready,
    .serial_clock_in, .serial_data_in, .serial_clock_out,
    .serial_data_out, .serial_out_enable, .direction_echo_n,
    .analog_enable, .pll_locked, .pll_range_sel, .rate_mult_sel,
    .edge_rate_sel);

  smc_link_partner p (
    .serial_clock_out, .serial_data_out, .serial_out_enable,
    .serial_clock_in, .serial_data_in);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Bounded wait; a miss shows up as a failed compare
  task automatic wait_for(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 400) begin
      cyc(1);
      n++;
    end
    chk(s, v);
  endtask : wait_for

  task automatic power_down(input logic d);
    @(posedge clk);
    mode <= smc_pkg::MODE_PD;
    direction_select <= d;
    passthrough_enable <= 1'b0;
    cyc(4);
    p.rx_q.delete();
    chk(analog_enable, 1'b0);
    chk(serial_out_enable, 1'b0);
    chk(pll_locked, 1'b0);
    chk(parallel_data_out, 12'h000);
    chk(direction_echo_n, !d);
    chk(parallel_data_oe, 1'b0);
    chk(word_clock_oe, d);
    if (d) chk(word_clock_out, 1'b1);
  endtask : power_down

  task automatic start(input logic [1:0] m, input logic [1:0] r);
    @(posedge clk);
    mode <= m;
    rate <= r;
    cyc(1);
  endtask : start

  task automatic strobe(input logic [11:0] d);
    @(posedge clk);
    parallel_data_in <= d;
    strobe_in <= 1'b1;
    repeat (2) @(posedge clk);
    strobe_in <= 1'b0;
    cyc(2);
  endtask : strobe

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  initial begin
    #400000;
    mismatches++;
    close_out();
  end

  initial begin
    int          n, n1, n2;
    logic        lvl, full, prev;
    logic [11:0] w;
    logic [11:0] got [$];
    smc_row_type r;
    full = 1'b0;
    cyc(2);
    chk(pll_locked, 1'b0);
    chk(parallel_data_out, 12'h000);
    chk(direction_echo_n, 1'b0);
    cyc(8);
    @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      power_down(r.dir);
      start(r.mode, r.rate);
      wait_for(pll_locked, 1'b1, n);
      chk(analog_enable, 1'b1);
      chk(pll_range_sel, r.dir ? r.mode : 2'h0);
      chk(rate_mult_sel, r.dir ? r.rate : 2'h0);
      chk(edge_rate_sel, r.dir ? 2'h0 : r.mode);
      if (r.dir) begin
        wait_for(serial_clock_out, 1'b1, n);
        wait_for(serial_clock_out, 1'b0, n1);
        wait_for(serial_clock_out, 1'b1, n2);
        chk(n1 + n2, r.num);
        repeat (200) if (p.rx_q.size() == 0) cyc(1);
        chk(p.rx_q[0], 12'h000);
      end else begin
        lvl = (r.rate != smc_pkg::PW_7_HL);
        chk(word_clock_out, lvl);
        w = 12'ha5c ^ 12'(i);
        fork
          p.send_word(w);
        join_none
        wait_for(word_clock_out, !lvl, n);
        chk(parallel_data_out, w);
        wait_for(word_clock_out, lvl, n);
        chk(n, r.num * 8);
      end
    end
    // Turn to serializer without power-down: last word must stay
    @(posedge clk);
    direction_select <= 1'b1;
    #2;
    chk(direction_echo_n, 1'b0);
    cyc(4);
    chk(parallel_data_out, 12'ha5b);
    chk(parallel_data_oe, 1'b0);
    // Strobe before lock is dropped; burst then overfills the buffer
    power_down(1'b1);
    start(smc_pkg::MODE_MED, smc_pkg::RATE_DIV3);
    cyc(5);
    chk(capture_ready, 1'b0);
    strobe(12'hbad);
    wait_for(pll_locked, 1'b1, n);
    for (int k = 1; k <= 10; k++) begin
      strobe(12'(k));
      if (capture_ready === 1'b0) full = 1'b1;
    end
    chk(full, 1'b1);
    cyc(1800);
    foreach (p.rx_q[j]) if (p.rx_q[j] !== 12'h000) got.push_back(p.rx_q[j]);
    chk(got.size(), 8);
    foreach (got[j]) chk(got[j], 12'(j + 1));
    // Settings are frozen while running
    @(posedge clk);
    rate <= smc_pkg::RATE_OC;
    cyc(4);
    chk(rate_mult_sel, smc_pkg::RATE_DIV3);
    // Pass-through: every serial clock pulse reaches the word clock
    @(posedge clk);
    passthrough_enable <= 1'b1;
    cyc(4);
    n = 0;
    fork
      p.send_word(12'h000);
    join_none
    repeat (110) begin
      prev = word_clock_out;
      cyc(1);
      if (prev === 1'b0 && word_clock_out === 1'b1) n++;
    end
    chk(n, 12);
    // Deserializer end of pass-through: reference low, clock on strobe
    power_down(1'b0);
    start(smc_pkg::MODE_MED, smc_pkg::PW_7_LH);
    @(posedge clk);
    ref_low <= 1'b1;
    passthrough_enable <= 1'b1;
    strobe_in <= 1'b1;
    cyc(3);
    chk(serial_out_enable, 1'b1);
    chk(serial_clock_out, 1'b1);
    @(posedge clk);
    strobe_in <= 1'b0;
    cyc(3);
    chk(serial_clock_out, 1'b0);
    chk(pll_locked, 1'b0);
    // Reset in mid-run: core clears, then relocks on its own
    @(posedge clk);
    ref_low <= 1'b0;
    reset_n <= 1'b0;
    cyc(3);
    chk(pll_locked, 1'b0);
    chk(analog_enable, 1'b0);
    @(posedge clk);
    reset_n <= 1'b1;
    cyc(1);
    chk(analog_enable, 1'b0);
    wait_for(pll_locked, 1'b1, n);
    chk(edge_rate_sel, smc_pkg::MODE_MED);
    close_out();
  end
endmodule : smc_mode_control_tb

`default_nettype wire
